// file: key_access.sv
// key-protected access layer: keys, reset handshake, info block, tx pacing, sync events
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
// Contract
// - pulse event on each sync rising edge
// - two idle bits between multibyte bytes
// - delay enable adds two more bits
// - first byte after turnaround: guard only
// - info block readout, 16 or 8 bytes
// - info block field layout fixed
// - 64-bit keys, low byte first, three keys
// - keys any order, prog survives erase
// - prog needs unlocked, ends on done
// - user row needs lock, write clears
// - key status readable per key
// - signature asserts reset, zero releases
// - erase unlocks; locked refuses system bus
// - brownout forced on during erase
// - user row writes only first 32 bytes
// - commit copies ram, clears flag
// - no ram readback in user row mode
// - key takes 64 bits, no reply
module key_access
   import key_access_pkg::*;
#(
   // arbitrary neutral identity content
   parameter logic [55:0] FAMILY_IDENTIFIER = 56'h31_4d_41_46_56_45_44,
   parameter logic [23:0] MEMORY_CTRL_VERSION = 24'h30_2e_31,
   parameter logic [23:0] DEBUG_LOGIC_VERSION = 24'h30_2e_31,
   parameter logic [7:0] DEBUG_OSC_FREQUENCY = 8'h33,
   parameter logic [7:0] RESET_SIGNATURE = 8'h59
) (
   input wire logic clk,
   input wire logic rst,
   // control-space register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // key instruction payload
   input wire logic key_start,
   input wire logic key_byte_valid,
   input wire logic [7:0] key_byte,
   input wire logic info_req,
   input wire logic info_full,
   // multi-byte load data toward the line
   input wire logic load_valid,
   input wire logic load_first,
   input wire logic [7:0] load_data,
   output logic load_ready,
   // byte transmitter
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic [2:0] tx_idle_bits,
   input wire logic tx_ready,
   // sync character edge event
   input wire logic sync_active,
   input wire logic rx_line,
   output logic sync_edge_event,
   // system side
   input wire logic port_disable,
   input wire logic lock_fuse,
   input wire logic sys_sleep,
   input wire logic erase_done,
   input wire logic prog_done,
   input wire logic [2:0] brownout_fuse_level,
   output logic sys_reset,
   output logic erase_start,
   output logic sys_bus_allow,
   output logic brownout_force,
   output logic [2:0] brownout_level,
   // ram access filter in user row mode
   input wire logic ram_wr_req,
   input wire logic [15:0] ram_addr,
   input wire logic [7:0] ram_wdata,
   output logic ram_wr_allow,
   output logic ram_rd_allow,
   // user row copy
   output logic urow_wr_valid,
   output logic [4:0] urow_wr_addr,
   output logic [7:0] urow_wr_data
);
   function automatic logic [7:0] info_byte(input logic [4:0] idx);
      logic [127:0] blk;
      blk = {DEBUG_OSC_FREQUENCY, INFO_RESERVED, DEBUG_LOGIC_VERSION,
             MEMORY_CTRL_VERSION, INFO_RESERVED, FAMILY_IDENTIFIER};
      info_byte = blk[{idx[3:0], 3'h0} +: 8];
   endfunction : info_byte

   function automatic logic is_write(input logic [3:0] a, input logic [3:0] target,
                                     input logic w);
      is_write = w && (a == target);
   endfunction : is_write

   logic inter_byte_delay_enable;
   logic clkreq;
   logic [7:0] reset_request_reg;
   logic erase_key, prog_key, user_row_key_bit;
   logic nonvolatile_prog_flag, user_row_prog_flag, user_row_commit_bit;
   logic erased, erase_busy;
   logic [63:0] key_shift;
   logic [2:0] key_count;
   logic key_done;
   logic [63:0] key_value;
   logic reset_release;
   logic lock_state_flag;
   logic rx_prev;
   logic info_active;
   logic [4:0] info_idx, info_len;
   logic tx_take;
   logic tx_first;
   logic [7:0] row_buf [0:31];
   copy_state_t copy_state;
   logic [4:0] copy_idx;

   assign lock_state_flag = lock_fuse && !erased;
   assign reset_release = sys_reset && is_write(addr, RESET_REQUEST_ADDR, wr)
                          && (wdata == RESET_RELEASE);
   // only a full eight-byte payload is judged; nothing is sent back
   assign key_done = key_byte_valid && (key_count == KEY_LAST_BYTE);
   assign key_value = {key_byte, key_shift[63:8]};

   // key bytes arrive low byte first
   always_ff @(posedge clk) begin
      if (rst || key_start) begin
         key_count <= '0;
         key_shift <= '0;
      end else if (key_byte_valid) begin
         key_count <= key_count + 3'h1;
         key_shift <= key_value;
      end
   end

   // one bit per key, so erase never disturbs prog
   always_ff @(posedge clk) begin
      if (rst || port_disable) begin
         erase_key <= 1'b0;
      end else if (key_done && key_value == KEY_CHIP_ERASE) begin
         erase_key <= 1'b1;
      end
   end

   // prog key ends with programming done or port reset
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_key <= 1'b0;
         nonvolatile_prog_flag <= 1'b0;
      end else if (key_done && key_value == KEY_NV_PROG) begin
         prog_key <= 1'b1;
      end else if (nonvolatile_prog_flag && (prog_done || reset_release)) begin
         prog_key <= 1'b0;
         nonvolatile_prog_flag <= 1'b0;
      end else if (reset_release && prog_key && !lock_state_flag) begin
         nonvolatile_prog_flag <= 1'b1;
      end
   end

   // user row key: a new match wins over a clearing write
   always_ff @(posedge clk) begin
      if (rst) begin
         user_row_key_bit <= 1'b0;
      end else if (key_done && key_value == KEY_USER_ROW) begin
         user_row_key_bit <= 1'b1;
      end else if (is_write(addr, KEY_STATUS_ADDR, wr) && wdata[KEY_UROW_BIT]) begin
         user_row_key_bit <= 1'b0;
      end
   end

   // reset request register drives the system reset
   always_ff @(posedge clk) begin
      if (rst) begin
         reset_request_reg <= RESET_RELEASE;
         sys_reset <= 1'b0;
      end else if (is_write(addr, RESET_REQUEST_ADDR, wr)) begin
         reset_request_reg <= wdata;
         if (wdata == RESET_SIGNATURE) begin
            sys_reset <= 1'b1;
         end else if (wdata == RESET_RELEASE) begin
            sys_reset <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         inter_byte_delay_enable <= 1'b0;
         clkreq <= CLKREQ_RESET;
      end else begin
         if (is_write(addr, CTRL_REG_ADDR, wr)) begin
            inter_byte_delay_enable <= wdata[DELAY_ENABLE_BIT];
         end
         if (is_write(addr, SYSTEM_CONTROL_ADDR, wr)) begin
            clkreq <= wdata[CLKREQ_BIT];
         end
      end
   end

   // erase starts when the reset pulse ends with the erase key held
   always_ff @(posedge clk) begin
      if (rst) begin
         erase_busy <= 1'b0;
         erased <= 1'b0;
         erase_start <= 1'b0;
      end else begin
         erase_start <= reset_release && erase_key && !erase_busy;
         if (reset_release && erase_key && !erase_busy) begin
            erase_busy <= 1'b1;
         end else if (erase_busy && erase_done) begin
            erase_busy <= 1'b0;
            erased <= 1'b1;
         end
      end
   end

   // locked part sees control space only
   assign sys_bus_allow = !lock_state_flag;
   // brownout forced on with fuse level during erase
   assign brownout_force = erase_busy;
   assign brownout_level = brownout_fuse_level;

   // only the first 32 ram bytes are written in user row mode
   assign ram_wr_allow = ram_wr_req && (!user_row_prog_flag || ram_addr < UROW_SIZE);
   // no readback while user row programming
   assign ram_rd_allow = !user_row_prog_flag && !lock_state_flag;

   // the copy source is kept locally so the commit needs no ram read port
   always_ff @(posedge clk) begin
      if (user_row_prog_flag && ram_wr_req && ram_addr < UROW_SIZE) begin
         row_buf[ram_addr[4:0]] <= ram_wdata;
      end
   end

   // commit copies the row one to one, then drops the flag
   always_ff @(posedge clk) begin
      if (rst) begin
         copy_state <= COPY_IDLE;
         copy_idx <= '0;
         user_row_prog_flag <= 1'b0;
         user_row_commit_bit <= 1'b0;
         urow_wr_valid <= 1'b0;
         urow_wr_addr <= '0;
         urow_wr_data <= '0;
      end else begin
         urow_wr_valid <= 1'b0;
         case (copy_state)
            COPY_IDLE: begin
               // user row mode only on a locked part
               if (reset_release && user_row_key_bit && lock_state_flag) begin
                  user_row_prog_flag <= 1'b1;
               end
               if (user_row_prog_flag && is_write(addr, SYSTEM_CONTROL_ADDR, wr)
                   && wdata[COMMIT_BIT]) begin
                  user_row_commit_bit <= 1'b1;
                  copy_idx <= '0;
                  copy_state <= COPY_RUN;
               end
            end
            COPY_RUN: begin
               urow_wr_valid <= 1'b1;
               urow_wr_addr <= copy_idx;
               urow_wr_data <= row_buf[copy_idx];
               copy_idx <= copy_idx + 5'h1;
               if (copy_idx == UROW_LAST) begin
                  copy_state <= COPY_DONE;
               end
            end
            COPY_DONE: begin
               user_row_prog_flag <= 1'b0;
               user_row_commit_bit <= 1'b0;
               copy_state <= COPY_IDLE;
            end
            default: copy_state <= COPY_IDLE;
         endcase
      end
   end

   // rising edge of the line inside a sync character
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_prev <= 1'b1;
         sync_edge_event <= 1'b0;
      end else begin
         rx_prev <= rx_line;
         sync_edge_event <= sync_active && rx_line && !rx_prev;
      end
   end

   // info block readout starts on a request only while no readout is active
   always_ff @(posedge clk) begin
      if (rst) begin
         info_active <= 1'b0;
         info_idx <= '0;
         info_len <= '0;
      end else if (info_req && !info_active) begin
         info_active <= 1'b1;
         info_idx <= '0;
         info_len <= info_full ? INFO_LEN_FULL : INFO_LEN_SHORT;
      end else if (info_active && tx_take) begin
         info_idx <= info_idx + 5'h1;
         info_active <= (info_idx + 5'h1) != info_len;
      end
   end

   assign tx_take = !tx_valid || tx_ready;
   assign load_ready = tx_take && !info_active;

   // idle spacing per byte, guard time left to the line
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_data <= '0;
         tx_idle_bits <= IDLE_AFTER_TURN;
         tx_first <= 1'b0;
      end else if (tx_take) begin
         tx_valid <= info_active || load_valid;
         if (info_active) begin
            tx_data <= info_byte(info_idx);
            tx_first <= (info_idx == 5'h0);
         end else if (load_valid) begin
            tx_data <= load_data;
            tx_first <= load_first;
         end
         if ((info_active && info_idx == 5'h0) || (!info_active && load_first)) begin
            tx_idle_bits <= IDLE_AFTER_TURN;
         end else if (inter_byte_delay_enable) begin
            tx_idle_bits <= IDLE_BASE + IDLE_EXTRA;
         end else begin
            tx_idle_bits <= IDLE_BASE;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !rd) begin
         rdata <= RDATA_RESET;
      end else begin
         rdata <= RDATA_RESET;
         case (addr)
            CTRL_REG_ADDR: rdata[DELAY_ENABLE_BIT] <= inter_byte_delay_enable;
            KEY_STATUS_ADDR: begin
               rdata[KEY_UROW_BIT] <= user_row_key_bit;
               rdata[KEY_PROG_BIT] <= prog_key;
               rdata[KEY_ERASE_BIT] <= erase_key;
            end
            RESET_REQUEST_ADDR: rdata <= reset_request_reg;
            SYSTEM_CONTROL_ADDR: begin
               rdata[COMMIT_BIT] <= user_row_commit_bit;
               rdata[CLKREQ_BIT] <= clkreq;
            end
            SYSTEM_STATUS_ADDR: begin
               rdata[STAT_RSTSYS_BIT] <= sys_reset;
               rdata[STAT_SLEEP_BIT] <= sys_sleep;
               rdata[STAT_PROG_BIT] <= nonvolatile_prog_flag;
               rdata[STAT_UROW_BIT] <= user_row_prog_flag;
               rdata[STAT_LOCK_BIT] <= lock_state_flag;
            end
            default: rdata <= RDATA_RESET;
         endcase
      end
   end

   sequence s_commit;
      $rose(user_row_commit_bit);
   endsequence
   sequence s_copy_burst;
      urow_wr_valid [*8];
   endsequence

   property p_sync_event;
      @(posedge clk) disable iff (rst) sync_active && rx_line && !rx_prev |=> sync_edge_event;
   endproperty
   a_sync_event: assert property (p_sync_event) else $error("sync edge lost");
   property p_gap;
      @(posedge clk) disable iff (rst) tx_valid && !tx_first
         |-> tx_idle_bits == (inter_byte_delay_enable ? 3'h4 : 3'h2);
   endproperty
   a_gap: assert property (p_gap) else $error("wrong inter byte gap");
   property p_turn;
      @(posedge clk) disable iff (rst) tx_valid && tx_first |-> tx_idle_bits == 3'h0;
   endproperty
   a_turn: assert property (p_turn) else $error("delay added after turnaround");
   property p_rst_req;
      @(posedge clk) disable iff (rst)
         wr && addr == RESET_REQUEST_ADDR |=> reset_request_reg == $past(wdata);
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("reset request not stored");
   property p_rst_set;
      @(posedge clk) disable iff (rst) wr && addr == 4'h8 && wdata == RESET_SIGNATURE |=> sys_reset;
   endproperty
   a_rst_set: assert property (p_rst_set) else $error("reset not asserted");
   property p_rst_clr;
      @(posedge clk) disable iff (rst) wr && addr == 4'h8 && wdata == 8'h00 |=> !sys_reset;
   endproperty
   a_rst_clr: assert property (p_rst_clr) else $error("reset not released");
   property p_bad_key;
      @(posedge clk) disable iff (rst) key_done && !wr && !port_disable
         && key_value != KEY_CHIP_ERASE && key_value != KEY_NV_PROG
         && key_value != KEY_USER_ROW && !nonvolatile_prog_flag
         |=> $stable({erase_key, prog_key, user_row_key_bit});
   endproperty
   a_bad_key: assert property (p_bad_key) else $error("unknown key changed status");
   property p_prog_unlocked;
      @(posedge clk) disable iff (rst) $rose(nonvolatile_prog_flag) |-> !$past(lock_state_flag);
   endproperty
   a_prog_unlocked: assert property (p_prog_unlocked) else $error("prog while locked");
   property p_row_range;
      @(posedge clk) disable iff (rst) user_row_prog_flag && ram_wr_allow |-> ram_addr < 16'h0020;
   endproperty
   a_row_range: assert property (p_row_range) else $error("write outside user row");
   property p_no_readback;
      @(posedge clk) disable iff (rst) user_row_prog_flag |-> !ram_rd_allow;
   endproperty
   a_no_readback: assert property (p_no_readback) else $error("ram readback allowed");
   property p_copy;
      @(posedge clk) disable iff (rst) s_commit |=> ##1 s_copy_burst ##[24:26] !user_row_prog_flag;
   endproperty
   a_copy: assert property (p_copy) else $error("user row copy wrong");
   property p_bod;
      @(posedge clk) disable iff (rst)
         erase_busy |-> brownout_force && brownout_level == brownout_fuse_level;
   endproperty
   a_bod: assert property (p_bod) else $error("brownout not forced");
endmodule : key_access

// file: key_access_pkg.sv
// constants for the key-protected access layer of the debug port
package key_access_pkg;
   // register offsets on the control-space port
   localparam logic [3:0] CTRL_REG_ADDR = 4'h2;
   localparam logic [3:0] KEY_STATUS_ADDR = 4'h7;
   localparam logic [3:0] RESET_REQUEST_ADDR = 4'h8;
   localparam logic [3:0] SYSTEM_CONTROL_ADDR = 4'ha;
   localparam logic [3:0] SYSTEM_STATUS_ADDR = 4'hb;
   // field positions
   localparam int DELAY_ENABLE_BIT = 7;
   localparam int KEY_UROW_BIT = 5;
   localparam int KEY_PROG_BIT = 4;
   localparam int KEY_ERASE_BIT = 3;
   localparam int COMMIT_BIT = 1;
   localparam int CLKREQ_BIT = 0;
   localparam int STAT_RSTSYS_BIT = 5;
   localparam int STAT_SLEEP_BIT = 4;
   localparam int STAT_PROG_BIT = 3;
   localparam int STAT_UROW_BIT = 2;
   localparam int STAT_LOCK_BIT = 0;
   // reset values
   localparam logic [7:0] RESET_RELEASE = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic CLKREQ_RESET = 1'b1;
   // activation keys, least significant byte shifted first
   localparam logic [63:0] KEY_CHIP_ERASE = 64'h4e564d4572617365;
   localparam logic [63:0] KEY_NV_PROG = 64'h4e564d50726f6720;
   localparam logic [63:0] KEY_USER_ROW = 64'h4e564d5573267465;
   localparam logic [2:0] KEY_LAST_BYTE = 3'h7;
   // information block sizes and reserved content
   localparam logic [4:0] INFO_LEN_FULL = 5'h10;
   localparam logic [4:0] INFO_LEN_SHORT = 5'h08;
   localparam logic [7:0] INFO_RESERVED = 8'h00;
   // idle bits between transmitted bytes
   localparam logic [2:0] IDLE_AFTER_TURN = 3'h0;
   localparam logic [2:0] IDLE_BASE = 3'h2;
   localparam logic [2:0] IDLE_EXTRA = 3'h2;
   // user row window in ram
   localparam logic [15:0] UROW_SIZE = 16'h0020;
   localparam logic [4:0] UROW_LAST = 5'h1f;
   // user row copy states
   typedef enum logic [1:0] {
      COPY_IDLE = 2'b00,
      COPY_RUN = 2'b01,
      COPY_DONE = 2'b10
   } copy_state_t;
endpackage : key_access_pkg

// file: tool_model.sv
// debugger model: key bytes, info requests, sync characters, byte receiver
`timescale 1ns/1ns
module tool_model #(
   parameter int BIT_CYCLES = 8
) (
   // clock
   input wire logic clk,
   // key instruction
   output logic key_start,
   output logic key_byte_valid,
   output logic [7:0] key_byte,
   output logic info_req,
   output logic info_full,
   // byte receiver
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic [2:0] tx_idle_bits,
   output logic tx_ready,
   input wire logic slow,
   // sync character
   output logic sync_active,
   output logic rx_line
);
   logic [10:0] rxq[$];
   logic [3:0] cnt = 4'h0;
   initial begin
      {key_start, key_byte_valid, key_byte, info_req, info_full, sync_active} = '0;
      rx_line = 1'b1;
      tx_ready = 1'b1;
   end
   // slow mode stalls three cycles in four to stress the hold of each byte
   always @(posedge clk) begin
      cnt <= cnt + 4'h1;
      tx_ready <= !slow || (cnt[1:0] == 2'h3);
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         rxq.push_back({tx_idle_bits, tx_data});
   end
   // low byte first, eight bytes, no reply awaited
   task automatic send_key(input logic [63:0] k);
      @(posedge clk);
      key_start <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         key_start <= 1'b0;
         key_byte_valid <= 1'b1;
         key_byte <= k[8*i+:8];
      end
      @(posedge clk);
      key_byte_valid <= 1'b0;
   endtask : send_key
   task automatic req_info(input logic full);
      @(posedge clk);
      info_req <= 1'b1;
      info_full <= full;
      @(posedge clk);
      info_req <= 1'b0;
   endtask : req_info
   // slow alternating sync character, idle high afterwards
   task automatic send_sync();
      @(posedge clk);
      sync_active <= 1'b1;
      for (int i = 0; i < 10; i++) begin
         rx_line <= i[0];
         repeat (BIT_CYCLES) @(posedge clk);
      end
      sync_active <= 1'b0;
   endtask : send_sync
endmodule : tool_model

// file: tb_top.sv
// self-checking bench for the key access layer
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top import key_access_pkg::*;;
   // arbitrary identity content and signature
   localparam logic [55:0] FAM = 56'h37_36_35_34_33_32_31;
   localparam logic [23:0] MCV = 24'h61_62_63;
   localparam logic [23:0] DLV = 24'h64_65_66;
   localparam logic [7:0] OSC = 8'h39;
   localparam logic [7:0] SIG = 8'h5a;
   logic clk, rst, wr, rd, key_start, key_byte_valid, info_req, info_full;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, key_byte, load_data, tx_data, ram_wdata, urow_wr_data;
   logic load_valid, load_first, load_ready, tx_valid, tx_ready, slow;
   logic [2:0] tx_idle_bits, brownout_fuse_level, brownout_level;
   logic sync_active, rx_line, sync_edge_event, port_disable, lock_fuse, sys_sleep;
   logic erase_done, prog_done, sys_reset, erase_start, sys_bus_allow, brownout_force;
   logic ram_wr_req, ram_wr_allow, ram_rd_allow, urow_wr_valid;
   logic [15:0] ram_addr;
   logic [4:0] urow_wr_addr;
   logic [7:0] ud[32];
   logic [12:0] uq[$];
   logic [31:0] seed = 32'habe60d6b;
   int failures = 0, compares = 0, sync_events = 0, erase_starts = 0;
   key_access #(.FAMILY_IDENTIFIER(FAM), .MEMORY_CTRL_VERSION(MCV),
      .DEBUG_LOGIC_VERSION(DLV), .DEBUG_OSC_FREQUENCY(OSC), .RESET_SIGNATURE(SIG))
      i_key_access (.*);
   tool_model i_tool_model (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      if (erase_start === 1'b1) erase_starts++;
      if (sync_edge_event === 1'b1) sync_events++;
      if (urow_wr_valid === 1'b1) uq.push_back({urow_wr_addr, urow_wr_data});
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] info_exp(int i);
      logic [127:0] b;
      b = {OSC, INFO_RESERVED, DLV, MCV, INFO_RESERVED, FAM};
      return b[8*i+:8];
   endfunction : info_exp
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 `CHK("rdata", e, rdata)
   endtask : rd_chk
   task automatic port_reset(input logic lf);
      @(posedge clk);
      rst <= 1'b1;
      lock_fuse <= lf;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
   endtask : port_reset
   task automatic sys_pulse();
      wr_reg(RESET_REQUEST_ADDR, SIG);
      #1 `CHK("sys_reset", 1'b1, sys_reset)
      wr_reg(RESET_REQUEST_ADDR, 8'h00);
      #1 `CHK("sys_reset", 1'b0, sys_reset)
   endtask : sys_pulse
   task automatic wait_cnt(input int n, input bit rx);
      int k;
      for (k = 0; k < 3000 && (rx ? i_tool_model.rxq.size() : uq.size()) < n; k++)
         @(posedge clk);
      if (k == 3000) begin
         failures++;
         complete_run();
      end
   endtask : wait_cnt
   task automatic chk_byte(input logic [2:0] ei, input logic [7:0] ed);
      logic [10:0] v;
      v = i_tool_model.rxq.pop_front();
      `CHK("tx_idle_bits", ei, v[10:8])
      `CHK("tx_data", ed, v[7:0])
   endtask : chk_byte
   task automatic load(input logic [7:0] d, input logic f);
      int k;
      @(posedge clk);
      load_valid <= 1'b1;
      load_first <= f;
      load_data <= d;
      for (k = 0; k < 100; k++) begin
         @(negedge clk);
         if (load_ready === 1'b1) break;
      end
      if (k == 100) begin
         failures++;
         complete_run();
      end
      @(posedge clk);
      load_valid <= 1'b0;
   endtask : load
   initial begin
      logic [7:0] d0, d1;
      {addr, wdata, wr, rd, load_valid, load_first, load_data, port_disable} = '0;
      {sys_sleep, erase_done, prog_done, ram_wr_req, ram_addr, ram_wdata, slow} = '0;
      rst = 1'b1;
      lock_fuse = 1'b1;
      brownout_fuse_level = 3'(rnd());
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(SYSTEM_STATUS_ADDR, 8'h01);
      rd_chk(4'hf, 8'h00);
      i_tool_model.send_key({rnd(), rnd()});
      rd_chk(KEY_STATUS_ADDR, 8'h00);
      i_tool_model.send_key(KEY_NV_PROG);
      i_tool_model.send_key(KEY_CHIP_ERASE);
      rd_chk(KEY_STATUS_ADDR, 8'h18);
      sys_pulse();
      repeat (3) @(posedge clk);
      #1 `CHK("erase_start", 1, erase_starts)
      `CHK("brownout_force", 1'b1, brownout_force)
      `CHK("brownout_level", brownout_fuse_level, brownout_level)
      `CHK("sys_bus_allow", 1'b0, sys_bus_allow)
      rd_chk(SYSTEM_STATUS_ADDR, 8'h01);
      @(posedge clk) erase_done <= 1'b1;
      @(posedge clk) erase_done <= 1'b0;
      rd_chk(SYSTEM_STATUS_ADDR, 8'h00);
      `CHK("sys_bus_allow", 1'b1, sys_bus_allow)
      `CHK("brownout_force", 1'b0, brownout_force)
      `CHK("ram_rd_allow", 1'b1, ram_rd_allow)
      rd_chk(SYSTEM_CONTROL_ADDR, 8'h01);
      @(posedge clk) port_disable <= 1'b1;
      @(posedge clk) port_disable <= 1'b0;
      rd_chk(KEY_STATUS_ADDR, 8'h10);
      $display("test erase done");
      port_reset(1'b0);
      i_tool_model.send_key(KEY_NV_PROG);
      sys_pulse();
      rd_chk(SYSTEM_STATUS_ADDR, 8'h08);
      rd_chk(KEY_STATUS_ADDR, 8'h10);
      @(posedge clk) prog_done <= 1'b1;
      @(posedge clk) prog_done <= 1'b0;
      rd_chk(SYSTEM_STATUS_ADDR, 8'h00);
      rd_chk(KEY_STATUS_ADDR, 8'h00);
      $display("test programming done");
      port_reset(1'b1);
      i_tool_model.send_key(KEY_USER_ROW);
      sys_pulse();
      rd_chk(SYSTEM_STATUS_ADDR, 8'h05);
      `CHK("ram_rd_allow", 1'b0, ram_rd_allow)
      for (int a = 0; a < 33; a++) begin
         @(posedge clk);
         ram_wr_req <= 1'b1;
         ram_addr <= (a < 32) ? 16'(a) : (16'h0020 | 16'(rnd()));
         ram_wdata <= 8'(rnd());
         @(negedge clk);
         if (a < 32) ud[a] = ram_wdata;
         `CHK("ram_wr_allow", a < 32, ram_wr_allow)
      end
      @(posedge clk) ram_wr_req <= 1'b0;
      wr_reg(SYSTEM_CONTROL_ADDR, 8'h03);
      wait_cnt(32, 0);
      for (int a = 0; a < 32; a++) `CHK("urow", {5'(a), ud[a]}, uq[a])
      repeat (2) @(posedge clk);
      rd_chk(SYSTEM_STATUS_ADDR, 8'h01);
      wr_reg(KEY_STATUS_ADDR, 8'h20);
      rd_chk(KEY_STATUS_ADDR, 8'h00);
      $display("test user row done");
      slow <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         if (m == 2) wr_reg(CTRL_REG_ADDR, 8'h80);
         i_tool_model.req_info(m != 1);
         wait_cnt(m == 1 ? 8 : 16, 1);
         for (int i = 0; i < (m == 1 ? 8 : 16); i++)
            chk_byte(i == 0 ? 3'h0 : (m == 2 ? 3'h4 : 3'h2), info_exp(i));
      end
      d0 = 8'(rnd());
      d1 = 8'(rnd());
      load(d0, 1'b1);
      load(d1, 1'b0);
      wait_cnt(2, 1);
      chk_byte(3'h0, d0);
      chk_byte(3'h4, d1);
      $display("test transmit done");
      i_tool_model.send_sync();
      repeat (4) @(posedge clk);
      `CHK("sync_events", 5, sync_events)
      $display("test sync done");
      complete_run();
   end
endmodule : tb_top
